// ### mss_pkg.sv
// Constants, register map and carrier types for the multi-step speed sequencer.
// Assumes a 10 MHz pclk and a 32-bit APB master with byte addresses.
//
// Contract
// - Run mode 0 stops the drive after one full cycle until a new run command arrives.
// - Run mode 1 keeps the last step's reference and direction after one cycle.
// - Run mode 2 restarts the cycle automatically until a stop command arrives.
// - As a frequency reference, a negative step value commands reverse running.
// - Each of the sixteen step values is signed, limited to -100.0..100.0 percent, default 0.
// - Step values scale to maximum frequency, to rated voltage, or pass unscaled for PID.
// - With power retention on, position and frequency are saved at power loss and resumed; the code resumes only the step and elapsed time, not ref_val.
// - With power retention off, the sequence restarts from its beginning after power returns.
// - With stop retention on, position and frequency are recorded at stop and resumed at start; the code resumes only the step and elapsed time, not ref_val.
// - With stop retention off, every start begins the sequence from its first step; the code resumes a power-loss snapshot at the first start after reset.
// - Each step has a duration of 0.0 to 6500.0 units in tenths, default zero.
// - Each step carries a two-bit ramp time set selector applied while it is active.
// - The time unit setting picks seconds (0) or hours (1) for step durations.
// - Step 0 takes its value from a selectable source.
package mss_pkg;
  localparam int STEPS = 16;
  localparam int CLK_PERIOD_NS = 100;
  localparam int TENTH_SEC_NS = 100_000_000;
  localparam int TENTH_SEC_CYCLES = (TENTH_SEC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TENTHS_PER_HOUR_TENTH = 3600;
  localparam logic signed [15:0] STEP_MAX = 16'sh03E8;
  localparam logic signed [15:0] STEP_MIN = -16'sh03E8;
  localparam logic [15:0] DUR_MAX = 16'hFDE8;
  localparam logic signed [32:0] PCT_FULL = 33'sh003E8;
  localparam logic [3:0] LAST_STEP = 4'hF;
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MAXF = 8'h08;
  localparam logic [7:0] OFS_VOLT = 8'h0C;
  localparam logic [7:0] OFS_VAL = 8'h40;
  localparam logic [7:0] OFS_CFG = 8'h80;
  localparam logic [7:0] OFS_BLK_MASK = 8'hC0;
  // Control fields.
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_RET_PWR = 2;
  localparam int CTRL_RET_STOP = 3;
  localparam int CTRL_UNIT = 4;
  localparam int CTRL_SRC_LSB = 5;
  localparam int CTRL_KIND_LSB = 8;
  localparam logic [9:0] CTRL_RESET = 10'h000;
  localparam int CFG_RAMP_LSB = 16;
  typedef enum logic [1:0] {MSS_ONCE, MSS_HOLD_LAST, MSS_REPEAT, MSS_MODE_RSVD} mss_mode_t;
  typedef enum logic [1:0] {MSS_FREQ, MSS_VOLT, MSS_PID, MSS_KIND_RSVD} mss_kind_t;
  typedef enum logic [2:0] {
    MSS_SRC_STORED, MSS_SRC_AI1, MSS_SRC_AI2, MSS_SRC_AI3,
    MSS_SRC_PULSE, MSS_SRC_PID, MSS_SRC_KEYPAD, MSS_SRC_POT
  } mss_src_sel_t;
  typedef enum {MSS_IDLE, MSS_RUN, MSS_HOLD} mss_state_t;
  typedef struct packed {
    logic signed [15:0] ai1;
    logic signed [15:0] ai2;
    logic signed [15:0] ai3;
    logic signed [15:0] pulse;
    logic signed [15:0] pid;
    logic signed [15:0] keypad;
    logic signed [15:0] pot;
  } mss_src_t;
  typedef struct packed {
    logic [3:0] step;
    logic [15:0] elapsed;
    logic signed [31:0] ref_val;
  } mss_snap_t;
endpackage

// ### mss_sequencer.sv
// Multi-step speed sequencer with an APB register file.
// Assumes run, stop and power-fail pins are asynchronous; sources and
// nonvolatile snapshot inputs come from logic on pclk.
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/100ps
module mss_sequencer import mss_pkg::*; #(
  parameter int TENTH_CYCLES = TENTH_SEC_CYCLES,
  parameter int HOUR_TENTHS = TENTHS_PER_HOUR_TENTH
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Command pins.
  input wire logic run_cmd_pin,
  input wire logic stop_cmd_pin,
  input wire logic power_fail_pin,
  // Manual step selection from the terminal logic.
  input wire logic seq_enable,
  input wire logic [3:0] term_step_sel,
  // Alternative step 0 sources.
  input wire mss_src_t src_in,
  // Nonvolatile snapshot, sampled once after reset.
  input wire logic nv_resume_en,
  input wire mss_snap_t nv_snap_in,
  output mss_snap_t nv_snap_out,
  output logic nv_store,
  // Reference path.
  output logic signed [31:0] ref_out,
  output logic dir_rev,
  output logic [1:0] ramp_sel,
  output logic run_out,
  output logic [3:0] step_idx,
  output logic cycle_done
);
  ////////////////////////////////////////////////////////////////////////////
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic [2:0] sync3_r;
  logic run_ev, stop_ev, pf_ev;
  logic [9:0] ctrl_r;
  logic [15:0] maxf_r, volt_r;
  logic signed [15:0] val_r [STEPS];
  logic [15:0] dur_r [STEPS];
  logic [1:0] rsel_r [STEPS];
  mss_state_t state_r;
  logic [3:0] idx_r;
  logic [15:0] elapsed_r;
  logic [31:0] pre_r;
  logic [11:0] hr_r;
  logic tick_tenth, unit_tick;
  logic boot_r;
  logic resume_r;
  logic from_stop_r;
  logic resume_use;
  mss_snap_t saved_r;
  logic signed [15:0] act_val;
  logic signed [32:0] prod;
  logic signed [31:0] ref_nxt;
  logic [3:0] act_idx;
  logic step_end, cyc_end;
  logic apb_setup, apb_wr;
  logic [3:0] ridx;
  logic [31:0] rdata_nxt;
  logic rerr_nxt;
  mss_mode_t mode;
  mss_kind_t kind;

  assign mode = mss_mode_t'(ctrl_r[CTRL_MODE_LSB +: 2]);
  assign kind = mss_kind_t'(ctrl_r[CTRL_KIND_LSB +: 2]);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; edges are taken only from the second stage onward.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
      sync3_r <= 3'h0;
    end else begin
      sync1_r <= {power_fail_pin, stop_cmd_pin, run_cmd_pin};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end
  assign run_ev = sync2_r[0] & ~sync3_r[0];
  assign stop_ev = sync2_r[1] & ~sync3_r[1];
  assign pf_ev = sync2_r[2] & ~sync3_r[2];

  ////////////////////////////////////////////////////////////////////////////
  // APB: one wait-free access cycle, pready raised after the setup cycle.
  assign apb_setup = psel & ~penable & ~pready;
  assign apb_wr = psel & penable & pready & pwrite & ~pslverr;
  assign ridx = paddr[5:2];

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    rerr_nxt = 1'b0;
    if (paddr[1:0] != 2'h0) begin
      rerr_nxt = 1'b1;
    end else if (paddr == OFS_CTRL) begin
      rdata_nxt = {22'h00_0000, ctrl_r};
    end else if (paddr == OFS_STATUS) begin
      rdata_nxt = {24'h00_0000, resume_r, state_r == MSS_HOLD, state_r == MSS_RUN,
                   dir_rev, idx_r};
    end else if (paddr == OFS_MAXF) begin
      rdata_nxt = {16'h0000, maxf_r};
    end else if (paddr == OFS_VOLT) begin
      rdata_nxt = {16'h0000, volt_r};
    end else if ((paddr & OFS_BLK_MASK) == OFS_VAL) begin
      rdata_nxt = {{16{val_r[ridx][15]}}, val_r[ridx]};
    end else if ((paddr & OFS_BLK_MASK) == OFS_CFG) begin
      rdata_nxt = {14'h0000, rsel_r[ridx], dur_r[ridx]};
    end else begin
      rerr_nxt = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup & rerr_nxt;
      prdata <= apb_setup ? rdata_nxt : 32'h0000_0000;
    end
  end

  // Control and scale registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RESET;
      maxf_r <= 16'h0000;
      volt_r <= 16'h0000;
    end else if (apb_wr) begin
      if (paddr == OFS_CTRL) ctrl_r <= pwdata[9:0];
      if (paddr == OFS_MAXF) maxf_r <= pwdata[15:0];
      if (paddr == OFS_VOLT) volt_r <= pwdata[15:0];
    end
  end

  // Step tables; writes outside the legal span are clamped.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < STEPS; i++) begin
        val_r[i] <= 16'sh0000;
        dur_r[i] <= 16'h0000;
        rsel_r[i] <= 2'h0;
      end
    end else if (apb_wr) begin
      if ((paddr & OFS_BLK_MASK) == OFS_VAL) begin
        if ($signed(pwdata) > 32'(STEP_MAX)) val_r[ridx] <= STEP_MAX;
        else if ($signed(pwdata) < 32'(STEP_MIN)) val_r[ridx] <= STEP_MIN;
        else val_r[ridx] <= pwdata[15:0];
      end
      if ((paddr & OFS_BLK_MASK) == OFS_CFG) begin
        dur_r[ridx] <= (pwdata[15:0] > DUR_MAX) ? DUR_MAX : pwdata[15:0];
        rsel_r[ridx] <= pwdata[CFG_RAMP_LSB +: 2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Time base: tenth-second tick, divided again when the unit is hours.
  assign tick_tenth = (pre_r == 32'(TENTH_CYCLES - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= 32'h0000_0000;
      hr_r <= 12'h000;
    end else begin
      pre_r <= tick_tenth ? 32'h0000_0000 : pre_r + 32'h0000_0001;
      if (tick_tenth) hr_r <= (hr_r == 12'(HOUR_TENTHS - 1)) ? 12'h000 : hr_r + 12'h001;
    end
  end
  assign unit_tick = ctrl_r[CTRL_UNIT] ? (tick_tenth && hr_r == 12'(HOUR_TENTHS - 1))
                                       : tick_tenth;

  ////////////////////////////////////////////////////////////////////////////
  // Active step value and its scaled reference.
  assign act_idx = seq_enable ? idx_r : term_step_sel;
  assign step_end = (state_r == MSS_RUN) && (elapsed_r >= dur_r[idx_r]);
  assign cyc_end = step_end && (idx_r == LAST_STEP);
  // A position recorded at stop is honoured only while stop retention is still selected,
  // so clearing that digit between stop and start makes the next start begin at step 0.
  assign resume_use = resume_r && (!from_stop_r || ctrl_r[CTRL_RET_STOP]);

  always_comb begin
    act_val = val_r[act_idx];
    if (act_idx == 4'h0) begin
      case (mss_src_sel_t'(ctrl_r[CTRL_SRC_LSB +: 3]))
        MSS_SRC_AI1: act_val = src_in.ai1;
        MSS_SRC_AI2: act_val = src_in.ai2;
        MSS_SRC_AI3: act_val = src_in.ai3;
        MSS_SRC_PULSE: act_val = src_in.pulse;
        MSS_SRC_PID: act_val = src_in.pid;
        MSS_SRC_KEYPAD: act_val = src_in.keypad;
        MSS_SRC_POT: act_val = src_in.pot;
        default: act_val = val_r[0];
      endcase
    end
  end

  always_comb begin
    prod = 33'sh0_0000_0000;
    case (kind)
      MSS_FREQ: prod = act_val * $signed({1'b0, maxf_r});
      MSS_VOLT: prod = act_val * $signed({1'b0, volt_r});
      default: prod = 33'(act_val);
    endcase
    ref_nxt = (kind == MSS_PID) ? 32'(act_val) : 32'(prod / PCT_FULL);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state, step index and elapsed time.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= MSS_IDLE;
      idx_r <= 4'h0;
      elapsed_r <= 16'h0000;
    end else if (pf_ev || stop_ev) begin
      state_r <= MSS_IDLE;
    end else if (run_ev && state_r == MSS_IDLE) begin
      state_r <= MSS_RUN;
      idx_r <= resume_use ? saved_r.step : 4'h0;
      elapsed_r <= resume_use ? saved_r.elapsed : 16'h0000;
    end else if (cyc_end) begin
      elapsed_r <= 16'h0000;
      case (mode)
        MSS_ONCE: state_r <= MSS_IDLE;
        MSS_REPEAT: idx_r <= 4'h0;
        default: state_r <= MSS_HOLD;
      endcase
    end else if (step_end) begin
      idx_r <= idx_r + 4'h1;
      elapsed_r <= 16'h0000;
    end else if (state_r == MSS_RUN && unit_tick) begin
      elapsed_r <= elapsed_r + 16'h0001;
    end
  end

  // Resume snapshot: loaded from storage after reset, recorded at stop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_r <= 1'b1;
      resume_r <= 1'b0;
      from_stop_r <= 1'b0;
      saved_r <= '0;
    end else begin
      boot_r <= 1'b0;
      if (boot_r) begin
        resume_r <= nv_resume_en;
        from_stop_r <= 1'b0;
        saved_r <= nv_snap_in;
      end else if (stop_ev && state_r != MSS_IDLE) begin
        resume_r <= ctrl_r[CTRL_RET_STOP];
        from_stop_r <= 1'b1;
        saved_r <= '{step: idx_r, elapsed: elapsed_r, ref_val: ref_out};
      end else if (run_ev && state_r == MSS_IDLE) begin
        resume_r <= 1'b0;
      end else if (cyc_end && mode == MSS_ONCE) begin
        resume_r <= 1'b0;
      end
    end
  end

  // Power-loss store toward nonvolatile memory.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nv_store <= 1'b0;
      nv_snap_out <= '0;
    end else begin
      nv_store <= pf_ev && ctrl_r[CTRL_RET_PWR] && state_r != MSS_IDLE;
      if (pf_ev) nv_snap_out <= '{step: idx_r, elapsed: elapsed_r, ref_val: ref_out};
    end
  end

  // Outputs to the reference path.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_out <= 32'sh0000_0000;
      dir_rev <= 1'b0;
      ramp_sel <= 2'h0;
      run_out <= 1'b0;
      step_idx <= 4'h0;
      cycle_done <= 1'b0;
    end else begin
      ref_out <= ref_nxt;
      dir_rev <= (kind == MSS_FREQ) && act_val < 16'sh0000;
      ramp_sel <= rsel_r[act_idx];
      run_out <= (state_r == MSS_RUN) || (state_r == MSS_HOLD);
      step_idx <= act_idx;
      cycle_done <= cyc_end;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  step_clamp_a: assert property (val_r[ridx] <= STEP_MAX && val_r[ridx] >= STEP_MIN)
    else $error("step value outside span");
  dur_clamp_a: assert property (dur_r[ridx] <= DUR_MAX)
    else $error("step duration outside span");
  dir_sign_a: assert property (kind == MSS_FREQ && !apb_wr ##1 kind == MSS_FREQ
                               |-> dir_rev == ($past(act_val) < 16'sh0000))
    else $error("direction does not follow sign");
  pid_pass_a: assert property (kind == MSS_PID ##1 kind == MSS_PID
                               |-> ref_out == 32'($past(act_val)))
    else $error("pid reference was scaled");
  once_stop_a: assert property (cyc_end && mode == MSS_ONCE && !stop_ev && !pf_ev
                                |=> state_r == MSS_IDLE ##1 !run_out)
    else $error("once mode did not stop");
  hold_last_a: assert property (cyc_end && mode == MSS_HOLD_LAST && !stop_ev && !pf_ev
                                |=> state_r == MSS_HOLD && idx_r == LAST_STEP ##1 run_out)
    else $error("hold mode lost the last step");
  repeat_a: assert property (cyc_end && mode == MSS_REPEAT && !stop_ev && !pf_ev
                             |=> state_r == MSS_RUN && idx_r == 4'h0)
    else $error("repeat mode did not wrap");
  advance_a: assert property (step_end && idx_r != LAST_STEP && !stop_ev && !pf_ev
                              |=> idx_r == $past(idx_r) + 4'h1 && elapsed_r == 16'h0000)
    else $error("step did not advance");
  stop_keep_a: assert property (stop_ev && state_r == MSS_RUN && ctrl_r[CTRL_RET_STOP] && !boot_r
                                |=> resume_r && saved_r.step == $past(idx_r))
    else $error("stop position not recorded");
  restart_a: assert property (run_ev && state_r == MSS_IDLE && !resume_use && !pf_ev && !stop_ev
                              |=> idx_r == 4'h0 && elapsed_r == 16'h0000)
    else $error("start did not begin at step 0");
  pf_store_a: assert property (pf_ev && ctrl_r[CTRL_RET_PWR] && state_r == MSS_RUN
                               |=> nv_store && nv_snap_out.step == $past(idx_r))
    else $error("power loss snapshot missing");
  ramp_follow_a: assert property (!apb_wr |=> ramp_sel == $past(rsel_r[act_idx]))
    else $error("ramp selector mismatch");

  wrap_c: cover property (cyc_end && mode == MSS_REPEAT);
  hold_c: cover property (state_r == MSS_HOLD);
  resume_c: cover property (run_ev && state_r == MSS_IDLE && resume_r);
  pwr_store_c: cover property (nv_store);
endmodule

// ### mss_drive_model.sv
// Far-side model: command pins, terminal selection, sources, snapshot storage.
// Assumes pins change just after pclk rising edges.
`timescale 1ns/100ps
module mss_drive_model import mss_pkg::*; (
  // Clock and snapshot from the sequencer.
  input wire logic pclk,
  input wire mss_snap_t nv_snap_out,
  input wire logic nv_store,
  // Commands and selection.
  output logic run_cmd_pin,
  output logic stop_cmd_pin,
  output logic power_fail_pin,
  output logic seq_enable,
  output logic [3:0] term_step_sel,
  output mss_src_t src_in,
  // Stored snapshot.
  output logic nv_resume_en,
  output mss_snap_t nv_snap_in
);
  logic [2:0] pins_r = 3'h0;
  logic ok_r = 1'b0;
  mss_snap_t saved_r = '0;
  initial begin
    seq_enable = 1'b1;
    term_step_sel = 4'h0;
    src_in = {16'h0064, 16'h00C8, 16'h012C, 16'h0190, 16'h01F4, 16'h0258, 16'h02BC};
  end
  assign {power_fail_pin, stop_cmd_pin, run_cmd_pin} = pins_r;
  // Storage has no reset: it must survive the sequencer's power cycle.
  always_ff @(posedge pclk) begin
    if (nv_store) begin
      saved_r <= nv_snap_out;
      ok_r <= 1'b1;
    end
  end
  assign nv_resume_en = ok_r;
  assign nv_snap_in = saved_r;
  ////////////////////////////////////////////////////////////
  // Pin 0 run, 1 stop, 2 power loss; held four cycles for the synchroniser.
  task automatic pulse(input int p);
    @(posedge pclk);
    pins_r[p] <= 1'b1;
    repeat (4) @(posedge pclk);
    pins_r[p] <= 1'b0;
  endtask
  // Source j (ai1 is 1, pot is 7) takes j times the base value.
  task automatic set_src(input int b);
    src_in <= {16'(b), 16'(2 * b), 16'(3 * b), 16'(4 * b), 16'(5 * b), 16'(6 * b), 16'(7 * b)};
  endtask
  task automatic select(input logic en, input logic [3:0] k);
    @(posedge pclk);
    seq_enable <= en;
    term_step_sel <= k;
  endtask
endmodule

// ### multi_step_speed_sequencer_test.sv
// Testbench for the multi-step speed sequencer: APB tasks and call sequences.
// Assumes unit ticks shortened to 4 clocks and hours to 3 ticks.
`timescale 1ns/100ps
module multi_step_speed_sequencer_test import mss_pkg::*;;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, run_cmd_pin, stop_cmd_pin, power_fail_pin;
  logic seq_enable, nv_resume_en, nv_store, dir_rev, run_out, cycle_done;
  logic [3:0] term_step_sel, step_idx;
  logic [1:0] ramp_sel;
  logic signed [31:0] ref_out;
  mss_src_t src_in;
  mss_snap_t nv_snap_in, nv_snap_out;
  int n_fail = 0;
  int checks_done = 0;
  int n;
  always #50 pclk = ~pclk;
  mss_sequencer #(.TENTH_CYCLES(4), .HOUR_TENTHS(3)) mss_sequencer_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .run_cmd_pin, .stop_cmd_pin, .power_fail_pin, .seq_enable, .term_step_sel,
    .src_in, .nv_resume_en, .nv_snap_in, .nv_snap_out, .nv_store, .ref_out, .dir_rev,
    .ramp_sel, .run_out, .step_idx, .cycle_done);
  mss_drive_model mss_drive_model_i (
    .pclk, .nv_snap_out, .nv_store, .run_cmd_pin, .stop_cmd_pin, .power_fail_pin,
    .seq_enable, .term_step_sel, .src_in, .nv_resume_en, .nv_snap_in);
  ////////////////////////////////////////////////////////////
  function automatic int sv(input int i);
    return (i % 2) ? -(i * 30 + 10) : i * 30 + 10;
  endfunction
  function automatic logic hit(input int w, input logic [3:0] k);
    case (w)
      0: return step_idx === k;
      1: return cycle_done === 1'b1;
      default: return run_out === 1'b1;
    endcase
  endfunction
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (t >= 20) chk("pready", 32'h0, 32'h1);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask
  task automatic wait_for(input int w, input logic [3:0] k);
    int t;
    t = 0;
    while (!hit(w, k) && t < 500) begin
      @(posedge pclk);
      t++;
    end
    if (t >= 500) chk("wait", 32'(w), 32'hFF);
  endtask
  task automatic meas(input logic [3:0] k);
    n = 0;
    while (step_idx === k && n < 100) begin
      @(posedge pclk);
      n++;
    end
  endtask
  task automatic cfg();
    apb(1'b1, OFS_MAXF, 32'h7D0);
    apb(1'b1, OFS_VOLT, 32'hBB8);
    for (int i = 0; i < STEPS; i++) begin
      apb(1'b1, OFS_VAL + 8'(4 * i), 32'(sv(i)));
      apb(1'b1, OFS_CFG + 8'(4 * i), {14'h0, 2'(i), 16'h0003});
    end
  endtask
  task automatic power_cycle();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    #(30_000 * 100);
    n_fail++;
    $display("[ERR] watchdog expected finish seen hang");
    results();
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc("ctrl", OFS_CTRL, 32'h0);
    rdc("value", OFS_VAL + 8'h04, 32'h0);
    rdc("duration", OFS_CFG + 8'h04, 32'h0);
    apb(1'b1, OFS_VAL + 8'h04, 32'h000007D0);
    rdc("clamp hi", OFS_VAL + 8'h04, 32'h000003E8);
    apb(1'b1, OFS_VAL + 8'h04, 32'hFFFFF830);
    rdc("clamp lo", OFS_VAL + 8'h04, 32'hFFFFFC18);
    apb(1'b1, OFS_CFG + 8'h04, 32'h0003FFFF);
    rdc("dur clamp", OFS_CFG + 8'h04, 32'h0003FDE8);
    rdc("unmapped", 8'hC4, 32'h0);
    chk("unmapped err", err, 32'h1);
    apb(1'b1, 8'h41, 32'h1);
    chk("unaligned err", err, 32'h1);
    $display("registers test done");
    cfg();
    mss_drive_model_i.pulse(0);
    wait_for(2, 4'h0);
    for (int i = 0; i < STEPS; i++) begin
      wait_for(0, 4'(i));
      repeat (2) @(posedge pclk);
      chk("ref", ref_out, 32'(2 * sv(i)));
      chk("dir", dir_rev, sv(i) < 0);
      chk("ramp", ramp_sel, 32'(i % 4));
    end
    wait_for(1, 4'h0);
    repeat (20) @(posedge pclk);
    chk("run once", run_out, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h1);
    mss_drive_model_i.pulse(0);
    wait_for(1, 4'h0);
    repeat (20) @(posedge pclk);
    chk("hold run", run_out, 32'h1);
    chk("hold idx", step_idx, 32'hF);
    chk("hold ref", ref_out, 32'(2 * sv(15)));
    chk("hold dir", dir_rev, 32'h1);
    mss_drive_model_i.pulse(1);
    $display("modes test done");
    apb(1'b1, OFS_CTRL, 32'hA);
    mss_drive_model_i.pulse(0);
    wait_for(1, 4'h0);
    wait_for(0, 4'h2);
    chk("repeat", run_out, 32'h1);
    meas(4'h2);
    chk("sec span", n >= 7 && n <= 14, 32'h1);
    wait_for(0, 4'h5);
    mss_drive_model_i.pulse(1);
    repeat (4) @(posedge pclk);
    chk("stopped", run_out, 32'h0);
    mss_drive_model_i.pulse(0);
    wait_for(2, 4'h0);
    chk("resume idx", step_idx, 32'h5);
    mss_drive_model_i.pulse(1);
    apb(1'b1, OFS_CTRL, 32'h2);
    mss_drive_model_i.pulse(0);
    wait_for(2, 4'h0);
    chk("restart idx", step_idx, 32'h0);
    mss_drive_model_i.pulse(1);
    apb(1'b1, OFS_CTRL, 32'h12);
    mss_drive_model_i.pulse(0);
    wait_for(0, 4'h1);
    meas(4'h1);
    chk("hour span", n >= 23 && n <= 38, 32'h1);
    mss_drive_model_i.pulse(1);
    $display("retention test done");
    mss_drive_model_i.select(1'b0, 4'h3);
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, OFS_CTRL, 32'(k) << 8);
      repeat (3) @(posedge pclk);
      chk("kind", ref_out, k == 0 ? 32'hFFFFFF38 : k == 1 ? 32'hFFFFFED4 : 32'hFFFFFF9C);
    end
    mss_drive_model_i.select(1'b0, 4'h0);
    for (int s = 0; s < 16; s++) begin
      if (s == 8) mss_drive_model_i.set_src(-50);
      apb(1'b1, OFS_CTRL, 32'(s % 8) << 5);
      repeat (3) @(posedge pclk);
      n = (s % 8) * (s < 8 ? 200 : -100);
      chk("source", ref_out, s % 8 == 0 ? 32'h14 : 32'(n));
    end
    mss_drive_model_i.select(1'b1, 4'h0);
    $display("sources test done");
    apb(1'b1, OFS_CTRL, 32'h2);
    mss_drive_model_i.pulse(0);
    wait_for(0, 4'h6);
    mss_drive_model_i.pulse(2);
    repeat (2) @(posedge pclk);
    chk("no store", mss_drive_model_i.ok_r, 32'h0);
    power_cycle();
    rdc("no resume", OFS_STATUS, 32'h0);
    cfg();
    apb(1'b1, OFS_CTRL, 32'h6);
    mss_drive_model_i.pulse(0);
    wait_for(0, 4'h6);
    mss_drive_model_i.pulse(2);
    repeat (2) @(posedge pclk);
    chk("saved idx", mss_drive_model_i.saved_r.step, 32'h6);
    power_cycle();
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("resume", rd & 32'h8F, 32'h80);
    cfg();
    mss_drive_model_i.pulse(0);
    wait_for(2, 4'h0);
    chk("power resume idx", step_idx, 32'h6);
    $display("power test done");
    results();
  end
endmodule
